// *** inc/i2m_defines.vh ***
// register map, field positions and constants of the i2c master start block
`ifndef I2M_DEFINES_VH
`define I2M_DEFINES_VH
`define I2M_ADDR_W 3
`define I2M_A_STATUS 3'h0
`define I2M_A_CTRL 3'h1
`define I2M_A_CTRL2 3'h2
`define I2M_A_RELOAD 3'h3
`define I2M_A_BUF 3'h4
`define I2M_A_FLAGS 3'h5
`define I2M_ST_BF 0
`define I2M_ST_START 3
`define I2M_ST_STOP 4
`define I2M_C_MODE_HI 3
`define I2M_C_EN 5
`define I2M_C_WRITE_COLLISION_FLAG 7
`define I2M_MODE_MASTER 4'h8
`define I2M_C2_SEN 0
`define I2M_C2_REPEATED_START_ENABLE 1
`define I2M_C2_PEN 2
`define I2M_C2_ACK_RECEIVED_STATUS 6
`define I2M_C2_LOW_W 5
`define I2M_F_INT 0
`define I2M_F_BCL 1
`define I2M_F_INTEN 2
`define I2M_PHASE_W 2
`define I2M_PHASE_Q2 2'h1
`define I2M_PHASE_Q4 2'h3
`define I2M_BITS_PER_BYTE 4'h8
`endif

// *** rtl/i2m_master.v ***
// i2c master: bus monitor, start/repeated start, byte transmit, clock generator and registers
`timescale 1ns/1ns
`include "i2m_defines.vh"
// Summary of operation
// - start and stop flags clear on reset and while the port is disabled.
// - stop on the bus raises the port interrupt when enabled.
// - data line compared with driven level; mismatch sets bus collision.
// - no queueing: buffer write during a condition is dropped, write collision set.
// - master generates clocks, start and stop; repeated start keeps the bus.
// - eight bits per byte, acknowledge received after each sent byte.
// - reload from low 7 bits of reload register; rate fosc/(4*(n+1)).
// - clock generator starts on buffer write, stops after acknowledge.
// - generator counts down to zero and halts, decrementing on q2 and q4.
// - automatic reload waits for clock line sampled high.
// - start: both lines high, count, drive data low, set start flag, count, clear.
// - lines low at start, or clock low early: collision, abort, idle.
// - buffer write during start or repeated start leaves buffer, sets write collision.
// - low five bits of control 2 ignored until a condition completes.
// - repeated start enable accepted only when idle.
// - repeated start: clock low, release data, release clock, data low.
// - start flag set on bus condition; interrupt waits for generator timeout.
// - repeated start collision: data low while clock high; an early clock fall is not checked.
// - acknowledge stored in control 2 bit 6; interrupt after ninth clock.
// - reset disables the port and abandons any transfer.
module i2m_master
(
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // register port
  input wire [`I2M_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // bus lines
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe,
  // interrupt flag levels
  output wire port_interrupt_flag,
  output wire bus_collision_flag
);
  localparam S_IDLE = 4'h0;
  localparam S_SW1 = 4'h1;
  localparam S_SHOLD = 4'h2;
  localparam S_RLOW = 4'h3;
  localparam S_RREL = 4'h4;
  localparam S_RHI = 4'h5;
  localparam S_RHOLD = 4'h6;
  localparam S_TLOW = 4'h7;
  localparam S_TRISE = 4'h8;
  localparam S_THIGH = 4'h9;
  localparam S_PLOW = 4'hA;
  localparam S_PRISE = 4'hB;
  localparam S_PHIGH = 4'hC;
  localparam S_PDONE = 4'hD;

  // pin synchronisers, a change counts when stages two and three agree
  reg [2:0] scl_s_q;
  reg [2:0] sda_s_q;
  reg scl_q;
  reg sda_q;
  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_s_q <= {scl_s_q[1:0], scl_i};
      sda_s_q <= {sda_s_q[1:0], sda_i};
      if (scl_s_q[1] == scl_s_q[2])
        scl_q <= scl_s_q[2];
      if (sda_s_q[1] == sda_s_q[2])
        sda_q <= sda_s_q[2];
    end
  end

  // registers
  reg [3:0] state_q;
  reg [1:0] phase_q;
  reg [6:0] brg_q;
  reg brg_run_q;
  reg [7:0] reload_q;
  reg [7:0] buf_q;
  reg [7:0] shift_q;
  reg [3:0] bitcnt_q;
  reg bf_q;
  reg port_enable_q;
  reg [3:0] mode_q;
  reg write_collision_flag_q;
  reg start_q;
  reg stop_q;
  reg sen_q;
  reg repeated_start_enable_q;
  reg pen_q;
  reg ack_received_status_q;
  reg int_q;
  reg bcl_q;
  reg int_en_q;
  reg scl_low_q;
  reg sda_low_q;
  reg scl_d1_q;
  reg sda_d1_q;

  wire master_on = port_enable_q && (mode_q == `I2M_MODE_MASTER);
  wire tick = (phase_q == `I2M_PHASE_Q2) || (phase_q == `I2M_PHASE_Q4);
  wire brg_zero = brg_run_q && (brg_q == 7'h00) && tick;
  wire busy = (state_q != S_IDLE);
  wire in_start = (state_q == S_SW1) || (state_q == S_SHOLD) || (state_q == S_RLOW) ||
                  (state_q == S_RREL) || (state_q == S_RHI) || (state_q == S_RHOLD);
  wire wr_buf = reg_wr && (reg_addr == `I2M_A_BUF);
  wire wr_c2 = reg_wr && (reg_addr == `I2M_A_CTRL2);
  wire start_seen = scl_q && scl_d1_q && sda_d1_q && !sda_q;
  wire stop_seen = scl_q && scl_d1_q && !sda_d1_q && sda_q;
  wire drive_hi_bit = !sda_low_q;

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_low_q;
  assign sda_oe = sda_low_q;
  assign port_interrupt_flag = int_q;
  assign bus_collision_flag = bcl_q;

  always @(posedge sys_clk)
  begin
    if (!resetn || !port_enable_q)
    begin
      start_q <= 1'b0;
      stop_q <= 1'b0;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end
    else
    begin
      scl_d1_q <= scl_q;
      sda_d1_q <= sda_q;
      if (start_seen)
      begin
        start_q <= 1'b1;
        stop_q <= 1'b0;
      end
      else if (stop_seen)
      begin
        stop_q <= 1'b1;
        start_q <= 1'b0;
      end
    end
  end

  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      state_q <= S_IDLE;
      phase_q <= 2'h0;
      brg_q <= 7'h00;
      brg_run_q <= 1'b0;
      reload_q <= 8'h00;
      buf_q <= 8'h00;
      shift_q <= 8'h00;
      bitcnt_q <= 4'h0;
      bf_q <= 1'b0;
      port_enable_q <= 1'b0;
      mode_q <= 4'h0;
      write_collision_flag_q <= 1'b0;
      sen_q <= 1'b0;
      repeated_start_enable_q <= 1'b0;
      pen_q <= 1'b0;
      ack_received_status_q <= 1'b0;
      int_q <= 1'b0;
      bcl_q <= 1'b0;
      int_en_q <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_q + 2'h1;
      if (brg_run_q && tick && brg_q != 7'h00)
        brg_q <= brg_q - 7'h01;
      if (brg_zero)
        brg_run_q <= 1'b0;
      // software writes, cleared flags lose against hardware sets below
      if (reg_wr && reg_addr == `I2M_A_CTRL)
      begin
        mode_q <= reg_wdata[`I2M_C_MODE_HI:0];
        port_enable_q <= reg_wdata[`I2M_C_EN];
        write_collision_flag_q <= reg_wdata[`I2M_C_WRITE_COLLISION_FLAG];
      end
      if (reg_wr && reg_addr == `I2M_A_RELOAD)
        reload_q <= reg_wdata;
      if (reg_wr && reg_addr == `I2M_A_FLAGS)
      begin
        int_q <= reg_wdata[`I2M_F_INT];
        bcl_q <= reg_wdata[`I2M_F_BCL];
        int_en_q <= reg_wdata[`I2M_F_INTEN];
      end
      if (wr_c2 && master_on && !busy && !sen_q && !repeated_start_enable_q)
      begin
        if (reg_wdata[`I2M_C2_SEN])
        begin
          sen_q <= 1'b1;
          if (scl_q && sda_q)
          begin
            state_q <= S_SW1;
            brg_q <= reload_q[6:0];
            brg_run_q <= 1'b1;
          end
          else
          begin
            bcl_q <= 1'b1;
            sen_q <= 1'b0;
          end
        end
        else if (reg_wdata[`I2M_C2_REPEATED_START_ENABLE])
        begin
          repeated_start_enable_q <= 1'b1;
          scl_low_q <= 1'b1;
          state_q <= S_RLOW;
        end
        else if (reg_wdata[`I2M_C2_PEN])
        begin
          pen_q <= 1'b1;
          sda_low_q <= 1'b1;
          state_q <= S_PLOW;
          brg_q <= reload_q[6:0];
          brg_run_q <= 1'b1;
        end
      end
      if (wr_buf)
      begin
        if (busy || in_start || sen_q || repeated_start_enable_q || pen_q)
          write_collision_flag_q <= 1'b1;
        else if (master_on)
        begin
          buf_q <= reg_wdata;
          shift_q <= reg_wdata;
          bf_q <= 1'b1;
          bitcnt_q <= 4'h0;
          state_q <= S_TLOW;
          scl_low_q <= 1'b1;
          brg_q <= reload_q[6:0];
          brg_run_q <= 1'b1;
        end
      end
      if (master_on && stop_seen && int_en_q)
        int_q <= 1'b1;
      // arbitration, released data read low while clock high
      // rising clock and released stop data are judged only once settled
      if (busy && drive_hi_bit && scl_q && !sda_q && state_q != S_THIGH && state_q != S_RLOW &&
          state_q != S_TRISE && state_q != S_PHIGH)
      begin
        bcl_q <= 1'b1;
        state_q <= S_IDLE;
        sen_q <= 1'b0;
        repeated_start_enable_q <= 1'b0;
        pen_q <= 1'b0;
        scl_low_q <= 1'b0;
        sda_low_q <= 1'b0;
        brg_run_q <= 1'b0;
      end
      else
      begin
        case (state_q)
          S_IDLE:
          begin
          end
          S_SW1:
          begin
            if (!scl_q)
            begin
              bcl_q <= 1'b1;
              sen_q <= 1'b0;
              brg_run_q <= 1'b0;
              state_q <= S_IDLE;
            end
            else if (brg_zero)
            begin
              sda_low_q <= 1'b1;
              brg_q <= reload_q[6:0];
              brg_run_q <= 1'b1;
              state_q <= S_SHOLD;
            end
          end
          S_SHOLD, S_RHOLD:
          begin
            if (brg_zero)
            begin
              sen_q <= 1'b0;
              repeated_start_enable_q <= 1'b0;
              int_q <= 1'b1;
              state_q <= S_IDLE;
            end
          end
          S_RLOW:
          begin
            if (!scl_q && !brg_run_q)
            begin
              sda_low_q <= 1'b0;
              brg_q <= reload_q[6:0];
              brg_run_q <= 1'b1;
              state_q <= S_RREL;
            end
          end
          S_RREL:
          begin
            if (brg_zero)
            begin
              scl_low_q <= 1'b0;
              state_q <= S_RHI;
            end
          end
          S_RHI:
          begin
            if (scl_q && !brg_run_q)
            begin
              brg_q <= reload_q[6:0];
              brg_run_q <= 1'b1;
            end
            else if (brg_zero)
            begin
              sda_low_q <= 1'b1;
              brg_q <= reload_q[6:0];
              brg_run_q <= 1'b1;
              state_q <= S_RHOLD;
            end
          end
          S_TLOW:
          begin
            if (brg_zero)
            begin
              scl_low_q <= 1'b0;
              state_q <= S_TRISE;
            end
            else if (!scl_q)
            begin
              // data moves only once the clock line reads low
              sda_low_q <= (bitcnt_q < `I2M_BITS_PER_BYTE) ? !shift_q[7] : 1'b0;
              if (!brg_run_q)
              begin
                brg_q <= reload_q[6:0];
                brg_run_q <= 1'b1;
              end
            end
          end
          S_TRISE:
          begin
            if (scl_q)
            begin
              brg_q <= reload_q[6:0];
              brg_run_q <= 1'b1;
              state_q <= S_THIGH;
            end
          end
          S_THIGH:
          begin
            if (sda_low_q && !sda_q && !scl_q)
              state_q <= S_THIGH;
            if (bitcnt_q < `I2M_BITS_PER_BYTE && !sda_low_q && !sda_q)
            begin
              bcl_q <= 1'b1;
              sda_low_q <= 1'b0;
              brg_run_q <= 1'b0;
              state_q <= S_IDLE;
            end
            else if (brg_zero)
            begin
              scl_low_q <= 1'b1;
              if (bitcnt_q == `I2M_BITS_PER_BYTE)
              begin
                ack_received_status_q <= sda_q;
                int_q <= 1'b1;
                state_q <= S_IDLE;
              end
              else
              begin
                shift_q <= {shift_q[6:0], 1'b0};
                bitcnt_q <= bitcnt_q + 4'h1;
                if (bitcnt_q == `I2M_BITS_PER_BYTE - 4'h1)
                  bf_q <= 1'b0;
                state_q <= S_TLOW;
              end
            end
          end
          S_PLOW:
          begin
            if (brg_zero)
            begin
              scl_low_q <= 1'b0;
              state_q <= S_PRISE;
            end
          end
          S_PRISE:
          begin
            if (scl_q && !brg_run_q)
            begin
              brg_q <= reload_q[6:0];
              brg_run_q <= 1'b1;
            end
            else if (brg_zero)
            begin
              sda_low_q <= 1'b0;
              state_q <= S_PHIGH;
            end
          end
          S_PHIGH:
          begin
            if (sda_q && scl_q)
            begin
              brg_q <= reload_q[6:0];
              brg_run_q <= 1'b1;
              state_q <= S_PDONE;
            end
          end
          S_PDONE:
          begin
            if (brg_zero)
            begin
              pen_q <= 1'b0;
              int_q <= 1'b1;
              state_q <= S_IDLE;
            end
          end
          default:
            state_q <= S_IDLE;
        endcase
      end
      if (!port_enable_q)
      begin
        state_q <= S_IDLE;
        scl_low_q <= 1'b0;
        sda_low_q <= 1'b0;
        sen_q <= 1'b0;
        repeated_start_enable_q <= 1'b0;
        pen_q <= 1'b0;
        brg_run_q <= 1'b0;
      end
    end
  end

  // read data one cycle after the strobe
  always @(posedge sys_clk)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `I2M_A_STATUS: reg_rdata <= {3'h0, stop_q, start_q, 2'h0, bf_q};
        `I2M_A_CTRL: reg_rdata <= {write_collision_flag_q, 1'b0, port_enable_q, 1'b0, mode_q};
        `I2M_A_CTRL2: reg_rdata <= {1'b0, ack_received_status_q, 3'h0, pen_q, repeated_start_enable_q, sen_q};
        `I2M_A_RELOAD: reg_rdata <= reload_q;
        `I2M_A_BUF: reg_rdata <= buf_q;
        `I2M_A_FLAGS: reg_rdata <= {5'h00, int_en_q, bcl_q, int_q};
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end
endmodule // i2m_master

// *** sim/i2m_slave_model.sv ***
// behavioural i2c slave that acknowledges bytes and stretches the clock
`timescale 1ns/1ns
module i2m_slave_model
(
  // clock
  input wire sys_clk,
  // line levels
  input wire scl,
  input wire sda,
  // behaviour select
  input wire ack_en,
  input wire [3:0] stretch,
  // pulls, high = line low
  output reg scl_pull,
  output reg sda_pull,
  // last byte seen
  output reg [7:0] rx_byte
);
  integer bit_n;
  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    rx_byte = 8'h00;
    bit_n = 0;
  end
  // start or repeated start restarts the byte
  always @(negedge sda)
    if (scl)
      bit_n = 0;
  // eight bits per byte, msb first
  always @(posedge scl)
  begin
    if (bit_n < 8)
      rx_byte = {rx_byte[6:0], sda};
    bit_n = bit_n + 1;
  end
  // acknowledge from eighth fall to ninth fall, optional stretch
  always @(negedge scl)
  begin
    sda_pull = (bit_n == 8) && ack_en;
    if (bit_n == 9)
      bit_n = 0;
    if (stretch != 4'h0)
    begin
      scl_pull = 1'b1;
      // four clocks per unit, longer than the master's low phase
      repeat (4 * stretch) @(posedge sys_clk);
      scl_pull <= 1'b0;
    end
  end
endmodule // i2m_slave_model

// *** sim/i2m_master_chk.sv ***
// assertion checker of the i2c master start block
`timescale 1ns/1ns
`include "i2m_defines.vh"
module i2m_master_chk
(
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // register port
  input wire [`I2M_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // bus lines
  input wire scl_i,
  input wire scl_o,
  input wire scl_oe,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe,
  // flags
  input wire port_interrupt_flag,
  input wire bus_collision_flag
);
  reg en_q;
  reg [6:0] rl_q;
  reg [9:0] hi_q;
  reg [9:0] lo_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // tracked enable, reload and clock phase lengths
  always @(posedge sys_clk)
  begin
    if (!resetn)
      en_q <= 1'b0;
    else if (reg_wr && reg_addr == `I2M_A_CTRL)
      en_q <= reg_wdata[`I2M_C_EN];
    if (!resetn)
      rl_q <= 7'h00;
    else if (reg_wr && reg_addr == `I2M_A_RELOAD)
      rl_q <= reg_wdata[6:0];
    if (!resetn || scl_oe)
      hi_q <= 10'h000;
    else if (hi_q != 10'h3FF)
      hi_q <= hi_q + 10'h001;
    if (!resetn || !scl_oe)
      lo_q <= 10'h000;
    else if (lo_q != 10'h3FF)
      lo_q <= lo_q + 10'h001;
  end
  sequence s_sen_idle;
    reg_wr && reg_addr == `I2M_A_CTRL2 && reg_wdata[`I2M_C2_SEN] && en_q && scl_i && sda_i && !scl_oe && !sda_oe;
  endsequence
  sequence s_buf_wr;
    reg_wr && reg_addr == `I2M_A_BUF;
  endsequence
  sequence s_ctrl_rd;
    reg_rd && reg_addr == `I2M_A_CTRL;
  endsequence
  sequence s_cond;
    $rose(sda_oe) && !scl_oe && rl_q != 7'h00;
  endsequence
  property p_reset_quiet;
    $rose(resetn) |-> !scl_oe && !sda_oe && !port_interrupt_flag && !bus_collision_flag;
  endproperty
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  property p_status_off;
    reg_rd && reg_addr == `I2M_A_STATUS && !en_q && !$past(en_q) |=> reg_rdata[4:3] == 2'b00;
  endproperty
  property p_no_queue;
    s_sen_idle ##2 s_buf_wr ##2 s_ctrl_rd |=> reg_rdata[`I2M_C_WRITE_COLLISION_FLAG];
  endproperty
  property p_start_hold;
    s_cond |=> (sda_oe && !scl_oe) [*2];
  endproperty
  property p_coll_release;
    $rose(bus_collision_flag) |-> ##[0:4] (!scl_oe && !sda_oe);
  endproperty
  property p_stretch;
    !scl_oe && !scl_i |=> !scl_oe;
  endproperty
  property p_low_time;
    $fell(scl_oe) && !bus_collision_flag |-> lo_q >= {2'b00, rl_q, 1'b1};
  endproperty
  property p_high_time;
    $rose(scl_oe) |-> hi_q >= {2'b00, rl_q, 1'b1};
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet after reset");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  a_status_off: assert property (p_status_off) else $error("bus flags while disabled");
  a_no_queue: assert property (p_no_queue) else $error("queued buffer write not refused");
  a_start_hold: assert property (p_start_hold) else $error("start condition not held");
  a_coll_release: assert property (p_coll_release) else $error("lines kept after collision");
  a_stretch: assert property (p_stretch) else $error("clock driven during stretch");
  a_low_time: assert property (p_low_time) else $error("clock low phase short");
  a_high_time: assert property (p_high_time) else $error("clock high phase short");
endmodule // i2m_master_chk
bind i2m_master i2m_master_chk chk_u
(
  .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .port_interrupt_flag(port_interrupt_flag), .bus_collision_flag(bus_collision_flag)
);

// *** sim/i2m_master_tb.sv ***
// self-checking testbench of the i2c master start block
`timescale 1ns/1ns
`include "i2m_defines.vh"
module i2m_master_tb;
  reg sys_clk;
  reg resetn;
  reg [`I2M_ADDR_W-1:0] reg_addr;
  reg [7:0] reg_wdata;
  reg reg_wr;
  reg reg_rd;
  reg ack_en;
  reg [3:0] stretch;
  reg oth_scl;
  reg oth_sda;
  reg [7:0] rd_q;
  integer fail_count;
  integer comparisons;
  wire [7:0] reg_rdata;
  wire [7:0] rx_byte;
  wire scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda;
  wire port_interrupt_flag;
  wire bus_collision_flag;
  // pulled-up lines, wired-and of all drivers
  wire scl_i = ~(scl_oe | m_scl | oth_scl);
  wire sda_i = ~(sda_oe | m_sda | oth_sda);
  i2m_master dut_u
  (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .port_interrupt_flag(port_interrupt_flag),
    .bus_collision_flag(bus_collision_flag)
  );
  i2m_slave_model slv_u
  (
    .sys_clk(sys_clk), .scl(scl_i), .sda(sda_i), .ack_en(ack_en), .stretch(stretch),
    .scl_pull(m_scl), .sda_pull(m_sda), .rx_byte(rx_byte)
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task close_out;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  task chk(input string name, input [7:0] exp, input [7:0] got);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
    end
  end
  endtask
  task wr(input [`I2M_ADDR_W-1:0] a, input [7:0] d);
  begin
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  end
  endtask
  task rc(input [`I2M_ADDR_W-1:0] a, input [7:0] m, input [7:0] e);
  begin
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rd_q = reg_rdata;
    chk("register", e, rd_q & m);
  end
  endtask
  // poll a register bit under a bounded count
  task wait_bit(input [`I2M_ADDR_W-1:0] a, input [7:0] m, input [7:0] e);
    integer n;
  begin
    n = 0;
    rd_q = ~e;
    while ((rd_q & m) !== e && n < 400)
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      rd_q = reg_rdata;
      n = n + 1;
    end
    chk("poll", e, rd_q & m);
  end
  endtask
  task clear_flags;
  begin
    wr(`I2M_A_CTRL, 8'h28);
    wr(`I2M_A_FLAGS, 8'h04);
  end
  endtask
  task t_start;
  begin
    rc(`I2M_A_STATUS, 8'h18, 8'h00);
    wr(`I2M_A_CTRL2, 8'h01);
    wr(`I2M_A_BUF, 8'h5A);
    rc(`I2M_A_CTRL, 8'h80, 8'h80);
    wr(`I2M_A_CTRL2, 8'h02);
    wait_bit(`I2M_A_CTRL2, 8'h01, 8'h00);
    rc(`I2M_A_CTRL2, 8'h1F, 8'h00);
    rc(`I2M_A_STATUS, 8'h09, 8'h08);
    chk("lines", 8'h01, {6'h00, scl_oe, sda_oe});
    chk("int", 8'h01, {7'h00, port_interrupt_flag});
    clear_flags;
  end
  endtask
  task t_byte(input [7:0] d, input a, input [3:0] s);
  begin
    ack_en = a;
    stretch = s;
    wr(`I2M_A_BUF, d);
    chk("scl drive", 8'h01, {7'h00, scl_oe});
    rc(`I2M_A_STATUS, 8'h01, 8'h01);
    wr(`I2M_A_BUF, 8'hFF);
    wr(`I2M_A_CTRL2, 8'h02);
    rc(`I2M_A_CTRL, 8'h80, 8'h80);
    rc(`I2M_A_CTRL2, 8'h02, 8'h00);
    wait_bit(`I2M_A_FLAGS, 8'h01, 8'h01);
    chk("byte", d, rx_byte);
    rc(`I2M_A_STATUS, 8'h01, 8'h00);
    rc(`I2M_A_CTRL2, 8'h40, a ? 8'h00 : 8'h40);
    chk("scl held", 8'h01, {7'h00, scl_oe});
    clear_flags;
  end
  endtask
  task t_rstart;
  begin
    wr(`I2M_A_CTRL2, 8'h02);
    wait_bit(`I2M_A_CTRL2, 8'h02, 8'h00);
    rc(`I2M_A_STATUS, 8'h08, 8'h08);
    chk("lines", 8'h01, {6'h00, scl_oe, sda_oe});
    chk("int", 8'h01, {7'h00, port_interrupt_flag});
    clear_flags;
  end
  endtask
  task t_stop;
  begin
    wr(`I2M_A_CTRL2, 8'h04);
    wait_bit(`I2M_A_CTRL2, 8'h04, 8'h00);
    rc(`I2M_A_STATUS, 8'h18, 8'h10);
    chk("lines", 8'h00, {6'h00, scl_oe, sda_oe});
    chk("drive levels", 8'h00, {6'h00, scl_o, sda_o});
    clear_flags;
  end
  endtask
  task t_collision;
  begin
    @(posedge sys_clk);
    oth_scl <= 1'b1;
    oth_sda <= 1'b1;
    repeat (8) @(posedge sys_clk);
    wr(`I2M_A_CTRL2, 8'h01);
    wait_bit(`I2M_A_FLAGS, 8'h02, 8'h02);
    rc(`I2M_A_CTRL2, 8'h01, 8'h00);
    chk("lines", 8'h00, {6'h00, scl_oe, sda_oe});
    oth_scl <= 1'b0;
    oth_sda <= 1'b0;
    clear_flags;
    // another master starts then stops the bus
    @(posedge sys_clk);
    oth_sda <= 1'b1;
    wait_bit(`I2M_A_STATUS, 8'h08, 8'h08);
    @(posedge sys_clk);
    oth_sda <= 1'b0;
    wait_bit(`I2M_A_STATUS, 8'h10, 8'h10);
    chk("int", 8'h01, {7'h00, port_interrupt_flag});
  end
  endtask
  task t_disable_reset;
  begin
    wr(`I2M_A_CTRL, 8'h00);
    rc(`I2M_A_STATUS, 8'h18, 8'h00);
    clear_flags;
    wr(`I2M_A_CTRL2, 8'h01);
    wait_bit(`I2M_A_CTRL2, 8'h01, 8'h00);
    wr(`I2M_A_BUF, 8'hA4);
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    #1;
    chk("lines", 8'h00, {6'h00, scl_oe, sda_oe});
    rc(`I2M_A_CTRL, 8'hFF, 8'h00);
    rc(`I2M_A_STATUS, 8'h18, 8'h00);
  end
  endtask
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    fail_count = fail_count + 1;
    close_out;
  end
  initial
  begin
    fail_count = 0;
    comparisons = 0;
    resetn = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ack_en = 1'b1;
    stretch = 4'h0;
    oth_scl = 1'b0;
    oth_sda = 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    rc(`I2M_A_STATUS, 8'hFF, 8'h00);
    rc(`I2M_A_CTRL2, 8'hFF, 8'h00);
    wr(`I2M_A_RELOAD, 8'h84);
    wr(`I2M_A_CTRL, 8'h28);
    wr(`I2M_A_FLAGS, 8'h04);
    t_start;
    t_byte(8'hA4, 1'b1, 4'h5);
    t_byte(8'h3C, 1'b0, 4'h0);
    t_rstart;
    t_byte(8'hA5, 1'b1, 4'h0);
    t_stop;
    t_collision;
    t_disable_reset;
    close_out;
  end
endmodule // i2m_master_tb
